//--- verilog/eepc_top.sv
/*
 * eepc_top: program/erase controller for a 512-byte nonvolatile array.
 * assumes: apb master for registers; a cpu byte bus reaches the array.
 */
// Local design decisions: the register addresses and register access over APB.
// Function
// - auto mode ends cycle, clears enable
// - decode mode bits; protected block does nothing
// - latch captures valid array accesses; data from writes only
// - latest array write overrides earlier capture
// - latched reads return data, capture address
// - enable refused without latch or address
// - clearing enable never aborts sequence
// - one write cannot clear enable and latch
// - new cycle needs both bits cleared
// - reset idles sequencer, clears control
// - power-down disables array reads
// - array data withheld while enabled
// - only unprotected bytes, config byte alter
// - latched control waits for valid capture
// - top control bit is plain storage
// - timing from 35 us timebase divider
// - four 128-byte blocks, block erase
`timescale 1ns/1ps
`default_nettype none
module eepc_top (
	input wire logic CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic ABUS_SEL,
	input wire logic ABUS_WR,
	input wire logic [15:0] ABUS_ADDR,
	input wire logic [7:0] ABUS_WDATA,
	output logic [7:0] ABUS_RDATA,
	output logic ABUS_HIT,
	output logic HV_ON
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [7:0] ctrl_reg, ctrl_next; // nv_control_reg
	logic [4:0] prot_reg, prot_next; // [3:0] block protect, [4] config protect
	logic [10:0] div_reg, div_next; // timebase divider
	logic [eepc_pkg::ADDR_W-1:0] laddr_reg, laddr_next; // latched address
	logic lcfg_reg, lcfg_next; // latched address is the config byte
	logic [7:0] ldata_reg, ldata_next; // latched data
	logic lvalid_reg, lvalid_next; // a valid address was captured
	eepc_pkg::eepc_state_e st_reg, st_next; // sequencer
	logic [15:0] tcnt_reg, tcnt_next; // ticks in current phase
	logic [7:0] rsel_reg, rsel_next; // array read byte mux source
	logic rlat_reg, rlat_next; // read returns latched data
	logic [31:0] prdata_reg, prdata_next;
	logic slverr_next, slverr_reg;
	logic tick;
	logic [7:0] mem_rdata;
	logic [7:0] cfg_rdata;
	logic op_en;
	eepc_pkg::eepc_hv_s hv;
	eepc_pkg::eepc_abus_s abus;
	// ---------------------------------------------------------------
	// decode helpers
	// ---------------------------------------------------------------
	// true for an address inside the array window
	function automatic logic in_array(input logic [15:0] a);
		in_array = (a >= eepc_pkg::ARRAY_BASE) && (a < eepc_pkg::CONFIG_ADDR);
	endfunction
	// true for the nonvolatile config byte
	function automatic logic is_cfg(input logic [15:0] a);
		is_cfg = (a == eepc_pkg::CONFIG_ADDR);
	endfunction
	// duration of the high-voltage phase for a mode
	function automatic logic [15:0] hv_ticks(input eepc_pkg::eepc_mode_e m);
		case (m)
			eepc_pkg::EEPC_BYTE_PROG: hv_ticks = eepc_pkg::PROG_TICKS;
			eepc_pkg::EEPC_BYTE_ERASE: hv_ticks = eepc_pkg::BYTE_TICKS;
			eepc_pkg::EEPC_BLOCK_ERASE: hv_ticks = eepc_pkg::BLOCK_TICKS;
			default: hv_ticks = eepc_pkg::BULK_TICKS;
		endcase
	endfunction
	assign abus = '{sel: ABUS_SEL, wr: ABUS_WR, addr: ABUS_ADDR, wdata: ABUS_WDATA};
	wire logic apb_wr = PSEL && PENABLE && PWRITE;
	wire logic apb_rd = PSEL && !PENABLE && !PWRITE;
	wire logic pgm = ctrl_reg[eepc_pkg::PGM_BIT];
	wire logic lat = ctrl_reg[eepc_pkg::LAT_BIT];
	wire logic off = ctrl_reg[eepc_pkg::OFF_BIT];
	wire logic a_hit = abus.sel && (in_array(abus.addr) || is_cfg(abus.addr));
	wire eepc_pkg::eepc_mode_e mode =
		eepc_pkg::eepc_mode_e'({ctrl_reg[eepc_pkg::MODE_HI_BIT], ctrl_reg[eepc_pkg::MODE_LO_BIT]});
	// ---------------------------------------------------------------
	// sub-blocks
	// ---------------------------------------------------------------
	// 35 us tick
	eepc_tick u_tick (
		.clk(CLK),
		.rst(RST),
		.div(div_reg),
		.tick(tick)
	);
	eepc_mem u_mem (
		.clk(CLK),
		.rst(RST),
		.raddr(abus.addr[eepc_pkg::ADDR_W-1:0]),
		.rdata(mem_rdata),
		.cfg_rdata(cfg_rdata),
		.op_en(op_en),
		.cmd(hv),
		.blk_prot(prot_reg[3:0])
	);
	// ---------------------------------------------------------------
	// high-voltage command
	// ---------------------------------------------------------------
	always_comb begin
		hv.hv_on = (st_reg == eepc_pkg::EEPC_HV);
		hv.mode = mode;
		hv.addr = laddr_reg;
		hv.cfg = lcfg_reg;
		hv.data = ldata_reg;
		op_en = (st_reg == eepc_pkg::EEPC_DONE) &&
			(lcfg_reg ? !prot_reg[4] : !prot_reg[laddr_reg[8:7]]);
	end
	// ---------------------------------------------------------------
	// control register and latch next state
	// ---------------------------------------------------------------
	always_comb begin
		ctrl_next = ctrl_reg;
		prot_next = prot_reg;
		div_next = div_reg;
		laddr_next = laddr_reg;
		lcfg_next = lcfg_reg;
		ldata_next = ldata_reg;
		lvalid_next = lvalid_reg;
		if (lat && !pgm && a_hit) begin
			laddr_next = abus.addr[eepc_pkg::ADDR_W-1:0];
			lcfg_next = is_cfg(abus.addr);
			lvalid_next = 1'b1;
			if (abus.wr) ldata_next = abus.wdata;
		end
		if (!lat) lvalid_next = 1'b0;
		if (apb_wr && PADDR == eepc_pkg::NV_CONTROL_OFF) begin
			ctrl_next[eepc_pkg::SPARE_BIT] = PWDATA[eepc_pkg::SPARE_BIT];
			if (!lat || lvalid_reg) begin
				ctrl_next[eepc_pkg::OFF_BIT] = PWDATA[eepc_pkg::OFF_BIT];
				ctrl_next[eepc_pkg::MODE_HI_BIT] = PWDATA[eepc_pkg::MODE_HI_BIT];
				ctrl_next[eepc_pkg::MODE_LO_BIT] = PWDATA[eepc_pkg::MODE_LO_BIT];
				ctrl_next[eepc_pkg::AUTO_BIT] = PWDATA[eepc_pkg::AUTO_BIT];
				if (!pgm) ctrl_next[eepc_pkg::LAT_BIT] = PWDATA[eepc_pkg::LAT_BIT];
			end
			if (PWDATA[eepc_pkg::PGM_BIT] && lat && lvalid_reg &&
				st_reg == eepc_pkg::EEPC_IDLE) begin
				ctrl_next[eepc_pkg::PGM_BIT] = 1'b1;
			end else if (!PWDATA[eepc_pkg::PGM_BIT] && pgm &&
				!ctrl_reg[eepc_pkg::AUTO_BIT]) begin
				ctrl_next[eepc_pkg::PGM_BIT] = 1'b0;
			end
		end
		if (apb_wr && PADDR == eepc_pkg::PROTECT_OFF) prot_next = PWDATA[4:0];
		if (apb_wr && PADDR == eepc_pkg::DIVIDER_OFF && !lat) div_next = PWDATA[10:0];
		if (st_reg == eepc_pkg::EEPC_HV && tick && tcnt_reg + 16'h0001 >= hv_ticks(mode) &&
			ctrl_reg[eepc_pkg::AUTO_BIT]) begin
			ctrl_next[eepc_pkg::PGM_BIT] = 1'b0;
		end
	end
	// ---------------------------------------------------------------
	// sequencer next state
	// ---------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		tcnt_next = tcnt_reg;
		case (st_reg)
			eepc_pkg::EEPC_IDLE: begin
				tcnt_next = 16'h0000;
				if (pgm && lat && lvalid_reg) st_next = eepc_pkg::EEPC_HV;
			end
			eepc_pkg::EEPC_HV: begin
				if (tick && tcnt_reg < hv_ticks(mode)) tcnt_next = tcnt_reg + 16'h0001;
				// leave only after full time and enable low
				if ((tcnt_next >= hv_ticks(mode)) && !ctrl_next[eepc_pkg::PGM_BIT]) begin
					st_next = eepc_pkg::EEPC_DONE;
				end
			end
			eepc_pkg::EEPC_DONE: begin
				tcnt_next = 16'h0000;
				st_next = eepc_pkg::EEPC_FALL;
			end
			eepc_pkg::EEPC_FALL: begin
				if (tick) tcnt_next = tcnt_reg + 16'h0001;
				if (tcnt_reg >= eepc_pkg::FALL_TICKS && !lat && !pgm) st_next = eepc_pkg::EEPC_IDLE;
			end
			default: begin
				st_next = eepc_pkg::EEPC_IDLE;
			end
		endcase
	end
	// ---------------------------------------------------------------
	// array read path and apb read next
	// ---------------------------------------------------------------
	always_comb begin
		// config byte has no array cell, so it rides the latched-data path
		rlat_next = lat || (abus.sel && is_cfg(abus.addr));
		rsel_next = lat ? ldata_reg : cfg_rdata;
		prdata_next = prdata_reg;
		slverr_next = 1'b0;
		if (apb_rd) begin
			case (PADDR)
				eepc_pkg::NV_CONTROL_OFF: prdata_next = {24'h000000, ctrl_reg & eepc_pkg::CTRL_WMASK};
				eepc_pkg::PROTECT_OFF: prdata_next = {27'h0000000, prot_reg};
				eepc_pkg::DIVIDER_OFF: prdata_next = {21'h000000, div_reg};
				eepc_pkg::STATUS_OFF: prdata_next = {11'h000, cfg_rdata, lvalid_reg, lcfg_reg,
					laddr_reg, st_reg};
				default: begin
					prdata_next = 32'h00000000;
					slverr_next = 1'b1;
				end
			endcase
		end
	end
	assign ABUS_RDATA = (off || pgm || st_reg != eepc_pkg::EEPC_IDLE) ? 8'h00 :
		rlat_reg ? rsel_reg : mem_rdata;
	assign ABUS_HIT = a_hit;
	assign HV_ON = hv.hv_on;
	assign PREADY = 1'b1;
	assign PRDATA = prdata_reg;
	assign PSLVERR = slverr_reg && PSEL && PENABLE;
	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	// reset clears control, idles
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ctrl_reg <= eepc_pkg::CTRL_RESET;
			prot_reg <= eepc_pkg::PROT_RESET;
			div_reg <= eepc_pkg::DIV_RESET;
			laddr_reg <= '0;
			lcfg_reg <= 1'b0;
			ldata_reg <= 8'hFF;
			lvalid_reg <= 1'b0;
			st_reg <= eepc_pkg::EEPC_IDLE;
			tcnt_reg <= 16'h0000;
			rsel_reg <= 8'h00;
			rlat_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
			slverr_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			prot_reg <= prot_next;
			div_reg <= div_next;
			laddr_reg <= laddr_next;
			lcfg_reg <= lcfg_next;
			ldata_reg <= ldata_next;
			lvalid_reg <= lvalid_next;
			st_reg <= st_next;
			tcnt_reg <= tcnt_next;
			rsel_reg <= rsel_next;
			rlat_reg <= rlat_next;
			prdata_reg <= prdata_next;
			slverr_reg <= slverr_next;
		end
	end
endmodule
`default_nettype wire

//--- verilog/eepc_pkg.sv
/*
 * eepc_pkg: constants and carrier types of the nonvolatile program/erase controller.
 * assumes: APB slave with 32-bit data; the array sits on an internal byte bus.
 */
package eepc_pkg;
	// ---------------------------------------------------------------
	// register map (byte addresses on apb)
	// ---------------------------------------------------------------
	localparam logic [11:0] NV_CONTROL_OFF = 12'h000; // control register
	localparam logic [11:0] PROTECT_OFF = 12'h004; // block protect + config protect
	localparam logic [11:0] DIVIDER_OFF = 12'h008; // timebase divider
	localparam logic [11:0] STATUS_OFF = 12'h00C; // sequencer state, latched address
	// ---------------------------------------------------------------
	// control register fields
	// ---------------------------------------------------------------
	localparam int PGM_BIT = 0; // program_erase_enable
	localparam int AUTO_BIT = 1; // automatic termination
	localparam int LAT_BIT = 2; // bus_latch_control
	localparam int MODE_LO_BIT = 4; // mode_select_lo
	localparam int MODE_HI_BIT = 5; // mode_select_hi
	localparam int OFF_BIT = 6; // array_power_down
	localparam int SPARE_BIT = 7; // storage only
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'hF7; // bit 3 reads zero
	localparam logic [4:0] PROT_RESET = 5'h00; // blocks unprotected after reset
	localparam logic [10:0] DIV_RESET = 11'h001;
	// ---------------------------------------------------------------
	// array geometry: four 128-byte blocks
	// ---------------------------------------------------------------
	localparam int ADDR_W = 9;
	localparam int BLOCK_W = 7;
	localparam logic [15:0] ARRAY_BASE = 16'h0800;
	localparam logic [15:0] CONFIG_ADDR = 16'h0A00; // nonvolatile_config_reg location
	// ---------------------------------------------------------------
	// timing, in 35 us timebase ticks
	// ---------------------------------------------------------------
	localparam int TICK_NS = 35000; // timebase period
	localparam int PROG_TIME_US = 10000; // byte_program_time
	localparam int BYTE_ERASE_US = 10000; // byte_erase_time
	localparam int BLOCK_ERASE_US = 10000; // block_erase_time
	localparam int BULK_ERASE_US = 10000; // bulk_erase_time
	localparam int FALL_TIME_US = 105; // voltage_fall_time
	localparam logic [15:0] PROG_TICKS = 16'((PROG_TIME_US * 1000 + TICK_NS - 1) / TICK_NS);
	localparam logic [15:0] BYTE_TICKS = 16'((BYTE_ERASE_US * 1000 + TICK_NS - 1) / TICK_NS);
	localparam logic [15:0] BLOCK_TICKS = 16'((BLOCK_ERASE_US * 1000 + TICK_NS - 1) / TICK_NS);
	localparam logic [15:0] BULK_TICKS = 16'((BULK_ERASE_US * 1000 + TICK_NS - 1) / TICK_NS);
	localparam logic [15:0] FALL_TICKS = 16'((FALL_TIME_US * 1000 + TICK_NS - 1) / TICK_NS);
	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		EEPC_BYTE_PROG = 2'h0,
		EEPC_BYTE_ERASE = 2'h1,
		EEPC_BLOCK_ERASE = 2'h2,
		EEPC_BULK_ERASE = 2'h3
	} eepc_mode_e;
	typedef enum logic [1:0] {
		EEPC_IDLE = 2'h0,
		EEPC_HV = 2'h1,
		EEPC_DONE = 2'h3,
		EEPC_FALL = 2'h2
	} eepc_state_e;
	// array-side bus from the cpu
	typedef struct packed {
		logic sel;
		logic wr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} eepc_abus_s;
	// high-voltage command to the cell array
	typedef struct packed {
		logic hv_on;
		eepc_mode_e mode;
		logic [ADDR_W-1:0] addr;
		logic cfg;
		logic [7:0] data;
	} eepc_hv_s;
endpackage

//--- verilog/eepc_mem.sv
/*
 * eepc_mem: byte storage standing in for the cell array and its config byte.
 * assumes: one command per cycle; program ands data in, erase sets ones.
 */
`timescale 1ns/1ps
`default_nettype none
module eepc_mem (
	input wire logic clk,
	input wire logic rst,
	input wire logic [eepc_pkg::ADDR_W-1:0] raddr,
	output logic [7:0] rdata,
	output logic [7:0] cfg_rdata,
	input wire logic op_en,
	input wire eepc_pkg::eepc_hv_s cmd,
	input wire logic [3:0] blk_prot
);
	logic [7:0] mem [0:511]; // array bytes
	logic [7:0] cfg_reg; // config byte
	logic [7:0] rdata_reg;
	// ---------------------------------------------------------------
	// storage update and registered read
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		rdata_reg <= mem[raddr];
		if (op_en && !cmd.cfg) begin
			for (int i = 0; i < 512; i++) begin
				if (!blk_prot[i >> eepc_pkg::BLOCK_W]) begin
					case (cmd.mode)
						eepc_pkg::EEPC_BYTE_PROG: begin
							if (i == int'(cmd.addr)) mem[i] <= mem[i] & cmd.data;
						end
						eepc_pkg::EEPC_BYTE_ERASE: begin
							if (i == int'(cmd.addr)) mem[i] <= 8'hFF;
						end
						eepc_pkg::EEPC_BLOCK_ERASE: begin
							if ((i >> eepc_pkg::BLOCK_W) == int'(cmd.addr[8:7])) mem[i] <= 8'hFF;
						end
						default: begin
							mem[i] <= 8'hFF;
						end
					endcase
				end
			end
		end
	end
	// config byte: program ands, any erase sets ones
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_reg <= 8'hF0;
		end else if (op_en && cmd.cfg) begin
			cfg_reg <= (cmd.mode == eepc_pkg::EEPC_BYTE_PROG) ? (cfg_reg & cmd.data) : 8'hFF;
		end
	end
	assign rdata = rdata_reg;
	assign cfg_rdata = cfg_reg;
endmodule
`default_nettype wire

//--- verilog/eepc_tick.sv
/*
 * eepc_tick: timebase divider giving a one-cycle tick every div clocks.
 * assumes: div is nonzero; zero is treated as one.
 */
`timescale 1ns/1ps
`default_nettype none
module eepc_tick (
	input wire logic clk,
	input wire logic rst,
	input wire logic [10:0] div,
	output logic tick
);
	logic [10:0] cnt_reg; // clocks since last tick
	logic [10:0] cnt_next;
	logic tick_next;
	logic tick_reg;
	// ---------------------------------------------------------------
	// divider
	// ---------------------------------------------------------------
	always_comb begin
		tick_next = 1'b0;
		cnt_next = cnt_reg + 11'h001;
		if (cnt_next >= div) begin
			cnt_next = 11'h000;
			tick_next = 1'b1;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= 11'h000;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end
	assign tick = tick_reg;
endmodule
`default_nettype wire

//--- bench/eepc_cpu_model.sv
/*
 * eepc_cpu_model: cpu side of the array byte bus, one access per call.
 * assumes: the bench calls acc; the dut samples the bus on rising edges.
 */
`timescale 1ns/1ps
`default_nettype none
module eepc_cpu_model (
	input wire logic clk,
	input wire logic [7:0] rdata,
	output logic sel,
	output logic wr,
	output logic [15:0] addr,
	output logic [7:0] wdata
);
	// bus parked idle at time zero
	initial begin
		sel = 1'h0;
		wr = 1'h0;
		addr = 16'h0;
		wdata = 8'h0;
	end
	// single bus access
	// one access cycle, then the lines show the inverse of the last value
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk);
		sel <= 1'h1;
		wr <= w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		sel <= 1'h0;
		wr <= ~w;
		addr <= ~a;
		wdata <= ~d;
		// read data stands in the cycle after the access
		@(posedge clk);
		q = rdata;
	endtask
endmodule
`default_nettype wire

//--- bench/eepc_props.sv
/*
 * eepc_props: port-level checks on eepc_top.
 * assumes: bound to eepc_top; one clock, asynchronous reset RST.
 */
`timescale 1ns/1ps
`default_nettype none
module eepc_props (
	input wire logic CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic ABUS_SEL,
	input wire logic ABUS_WR,
	input wire logic [15:0] ABUS_ADDR,
	input wire logic [7:0] ABUS_RDATA,
	input wire logic ABUS_HIT,
	input wire logic HV_ON
);
	// ---------------------------------------------------------------
	// helper logic
	// ---------------------------------------------------------------
	logic [15:0] hv_cnt_reg; // length of the current high-voltage pulse
	logic [15:0] hv_cnt_next;
	logic set_pgm; // apb write asking for the enable
	logic in_array; // byte address inside the array
	assign set_pgm = PSEL && PENABLE && PWRITE && PADDR == eepc_pkg::NV_CONTROL_OFF
		&& PWDATA[eepc_pkg::PGM_BIT];
	assign in_array = ABUS_ADDR >= eepc_pkg::ARRAY_BASE && ABUS_ADDR <= 16'h9FF;
	// count cycles with high voltage applied
	always_comb begin
		hv_cnt_next = HV_ON ? hv_cnt_reg + 16'h1 : 16'h0;
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			hv_cnt_reg <= 16'h0;
		end else begin
			hv_cnt_reg <= hv_cnt_next;
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	reset_quiet_a: assert property (disable iff (1'h0) RST |-> !HV_ON && PRDATA == 32'h0)
		else $error("outputs active during reset");
	hv_cause_a: assert property ($rose(HV_ON) |-> $past(set_pgm) || $past(set_pgm, 2)
		|| $past(set_pgm, 3)) else $error("high voltage without enable write");
	hv_length_a: assert property ($fell(HV_ON) |->
		hv_cnt_reg >= eepc_pkg::PROG_TICKS - 16'h2) else $error("high voltage cut short");
	fall_gap_a: assert property ($fell(HV_ON) |-> !HV_ON [*3])
		else $error("new cycle before voltage fall");
	busy_read_a: assert property (HV_ON && ABUS_SEL && !ABUS_WR |=> ABUS_RDATA == 8'h0)
		else $error("array data shown while busy");
	hit_decode_a: assert property (ABUS_HIT == (ABUS_SEL
		&& (in_array || ABUS_ADDR == eepc_pkg::CONFIG_ADDR))) else $error("bad array hit");
	apb_ready_a: assert property (PREADY) // zero wait states
		else $error("ready low");
	slverr_cause_a: assert property (PSLVERR |-> PSEL && PENABLE && !PWRITE) // read phase only
		else $error("error outside a read access");
endmodule
bind eepc_top eepc_props props_u (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .ABUS_SEL(ABUS_SEL), .ABUS_WR(ABUS_WR), .ABUS_ADDR(ABUS_ADDR),
	.ABUS_RDATA(ABUS_RDATA), .ABUS_HIT(ABUS_HIT), .HV_ON(HV_ON));
`default_nettype wire

//--- bench/tb_top.sv
/*
 * tb_top: self-checking bench for eepc_top with a cpu byte bus model.
 * assumes: eepc_pkg, design files and the checker compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// ---------------------------------------------------------------
	// rows and signals
	// ---------------------------------------------------------------
	typedef struct packed {
		logic w;
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] exp;
	} eepc_reg_s;
	typedef struct packed {
		logic [1:0] mode;
		logic auto_on;
		logic [4:0] prot;
		logic [15:0] wa;
		logic [15:0] ra;
		logic [7:0] d;
		logic [15:0] chk;
		logic [7:0] exp;
	} eepc_op_s;
	localparam logic [11:0] CTL = eepc_pkg::NV_CONTROL_OFF;
	localparam logic [11:0] PRT = eepc_pkg::PROTECT_OFF;
	localparam logic [11:0] DIV = eepc_pkg::DIVIDER_OFF;
	logic clk = 1'h0;
	logic rst = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic abus_sel;
	logic abus_wr;
	logic [15:0] abus_addr;
	logic [7:0] abus_wdata;
	logic [7:0] abus_rdata;
	logic hv_on;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	// register writes and expected read-back
	eepc_reg_s regs [10] = '{'{1'h0, CTL, 32'h0, 32'h0}, '{1'h0, PRT, 32'h0, 32'h0},
		'{1'h0, DIV, 32'h0, 32'h1}, '{1'h1, CTL, 32'h80, 32'h80}, '{1'h1, CTL, 32'h1, 32'h0},
		'{1'h1, CTL, 32'h7A, 32'h72}, '{1'h1, CTL, 32'h0, 32'h0}, '{1'h1, PRT, 32'h1F, 32'h1F},
		'{1'h1, DIV, 32'h5, 32'h5}, '{1'h1, DIV, 32'h1, 32'h1}};
	// mode, auto, protect, write, read, data, checked byte, its value
	eepc_op_s ops [11] = '{'{2'h3, 1'h1, 5'h0, 16'h805, 16'h805, 8'h0, 16'h805, 8'hFF},
		'{2'h0, 1'h0, 5'h0, 16'h805, 16'h805, 8'h5A, 16'h805, 8'h5A},
		'{2'h1, 1'h1, 5'h0, 16'h805, 16'h805, 8'h0, 16'h805, 8'hFF},
		'{2'h0, 1'h1, 5'h0, 16'h900, 16'h900, 8'h33, 16'h900, 8'h33},
		'{2'h0, 1'h0, 5'h0, 16'h985, 16'h985, 8'h44, 16'h985, 8'h44},
		'{2'h2, 1'h0, 5'h0, 16'h985, 16'h910, 8'h0, 16'h900, 8'hFF},
		'{2'h0, 1'h1, 5'h0, 16'hA00, 16'hA00, 8'h70, 16'hA00, 8'h70},
		'{2'h3, 1'h1, 5'h8, 16'h805, 16'h805, 8'h0, 16'h985, 8'h44},
		'{2'h0, 1'h1, 5'h8, 16'h985, 16'h985, 8'h0, 16'h985, 8'h44},
		'{2'h0, 1'h1, 5'h0, 16'h805, 16'h805, 8'hFE, 16'h805, 8'hFE},
		'{2'h0, 1'h1, 5'h0, 16'h805, 16'h805, 8'hFD, 16'h805, 8'hFC}};
	eepc_top dut_u (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.ABUS_SEL(abus_sel), .ABUS_WR(abus_wr), .ABUS_ADDR(abus_addr),
		.ABUS_WDATA(abus_wdata), .ABUS_RDATA(abus_rdata), .ABUS_HIT(), .HV_ON(hv_on));
	eepc_cpu_model cpu_u (.clk(clk), .rdata(abus_rdata), .sel(abus_sel), .wr(abus_wr),
		.addr(abus_addr), .wdata(abus_wdata));
	// 200 MHz clock
	always #2.5 clk = ~clk;
	// cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			conclude();
		end
	end
	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// apb transfer: setup, then access until ready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'h1, a, d, q, e);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic e;
		apb(1'h0, a, 32'h0, q, e);
		check(q, x);
	endtask
	// array read through the cpu model, compared
	task automatic arc(input logic [15:0] a, input logic [7:0] x);
		logic [7:0] q;
		cpu_u.acc(1'h0, a, 8'h0, q);
		check({24'h0, q}, {24'h0, x});
	endtask
	// one program or erase sequence, software order kept
	task automatic op(input eepc_op_s r);
		logic [31:0] base;
		logic [31:0] v;
		logic e;
		logic [7:0] q;
		base = {26'h0, r.mode, 1'h0, 1'h1, r.auto_on, 1'h0};
		wr(PRT, {27'h0, r.prot});
		wr(CTL, base);
		cpu_u.acc(1'h1, 16'h9FF, ~r.d, q);
		cpu_u.acc(1'h1, r.wa, r.d, q);
		arc(r.ra, r.d);
		wr(CTL, base | 32'h1);
		if (r.auto_on) begin
			do apb(1'h0, CTL, 32'h0, v, e); while (v[0] !== 1'h0);
			check(v, base);
		end else begin
			repeat (20) @(posedge clk);
			arc(r.ra, 8'h0);
			wr(CTL, base & 32'hFB);
			rdc(CTL, base);
			check({31'h0, hv_on}, 32'h1);
		end
		while (hv_on === 1'h1) @(posedge clk);
		repeat (eepc_pkg::FALL_TICKS + 16'h4) @(posedge clk);
		wr(CTL, base | 32'h1);
		rdc(CTL, base);
		wr(CTL, 32'h0);
		arc(r.chk, r.exp);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [31:0] v;
		logic e;
		logic [7:0] q;
		// raise reset at time zero so the flops see its edge
		rst <= 1'h1;
		repeat (16) @(posedge clk);
		rst <= 1'h0;
		foreach (regs[i]) begin
			if (regs[i].w) begin
				wr(regs[i].a, regs[i].d);
			end
			rdc(regs[i].a, regs[i].exp);
		end
		// latched control refuses other bits until a valid capture
		wr(CTL, 32'h4);
		wr(CTL, 32'h85);
		rdc(CTL, 32'h84);
		cpu_u.acc(1'h1, 16'h700, 8'h11, q);
		wr(CTL, 32'h5);
		rdc(CTL, 32'h4);
		cpu_u.acc(1'h1, 16'h805, 8'hFF, q);
		wr(CTL, 32'h0);
		rdc(CTL, 32'h0);
		foreach (ops[i]) begin
			op(ops[i]);
		end
		// power-down hides the array
		wr(CTL, 32'h40);
		arc(16'h805, 8'h0);
		wr(CTL, 32'h0);
		arc(16'h805, 8'hFC);
		// unmapped register read
		apb(1'h0, 12'h10, 32'h0, v, e);
		check({31'h0, e}, 32'h1);
		// reset in the middle of a program cycle
		wr(CTL, 32'h6);
		cpu_u.acc(1'h1, 16'h811, 8'h0F, q);
		wr(CTL, 32'h7);
		repeat (5) @(posedge clk);
		check({31'h0, hv_on}, 32'h1);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		check({31'h0, hv_on}, 32'h0);
		repeat (16) @(posedge clk);
		rst <= 1'h0;
		rdc(CTL, 32'h0);
		conclude();
	end
endmodule
`default_nettype wire
